/* rtl/mtu_defines.svh */
// Purpose: Constants of the multi timer unit with wake-up
// Assumes: Included by its bare name from the timer and top design files
// Notes:   Definitions only
`ifndef MTU_DEFINES_SVH
`define MTU_DEFINES_SVH

// Reference clock and counting clock rates in Hz
`define MTU_REF_CLK_HZ 25000000
`define MTU_FAST_CLK_HZ 13560000
// Common divisor for the fractional rate accumulator
`define MTU_FRAC_SCALE 10000
// The slow counting clock is the fast one divided by this
`define MTU_SLOW_DIV 64

// Reset values
`define MTU_CNT_RST 16'h0000
`define MTU_FLAGS_RST 8'h00

// Interrupt flag word layout
`define MTU_FLAG_SETCLR_BIT 7
`define MTU_FLAG_WAKE_BIT 4

`endif

/* rtl/mtu_pkg.sv */
// Purpose: Types shared by the multi timer unit files
// Assumes: Nothing
// Notes:   Values live in mtu_defines.svh
package mtu_pkg;

    // Counting clock choice of a general timer
    typedef enum logic [1:0] {
        MTU_SEL_FAST = 2'b00,
        MTU_SEL_SLOW = 2'b01,
        MTU_SEL_WAKE = 2'b10
    } mtu_clk_sel_t;

    // General timer state
    typedef enum logic [1:0] {
        MTU_T_IDLE = 2'b00,
        MTU_T_ARMED = 2'b01,
        MTU_T_COUNT = 2'b10
    } mtu_tstate_t;

    // System power state
    typedef enum logic [1:0] {
        MTU_P_ACTIVE = 2'b00,
        MTU_P_STANDBY = 2'b01,
        MTU_P_CHECK = 2'b10
    } mtu_pstate_t;

    // Per timer configuration
    typedef struct packed {
        mtu_clk_sel_t clk_sel;
        logic auto_reload_option;
        logic irq_en;
        logic start_evt_en;
        logic stop_evt_en;
        logic [7:0] reload_high_byte;
        logic [7:0] reload_low_byte;
    } mtu_tcfg_t;

    // Write word of global_timer_ctrl
    typedef struct packed {
        logic [3:0] immediate_strobe;
        logic [3:0] running;
    } mtu_ctrl_t;

endpackage

/* rtl/mtu_gtimer.sv */
// Purpose: One general 16-bit down-counter with reload
// Assumes: Ticks are one-cycle enables on ref_clk
// Notes:   A stop request keeps the count for elapsed-time reads
`timescale 1ns/10ps
`default_nettype none
`include "mtu_defines.svh"

module mtu_gtimer (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Timebase enables
    input wire logic tick_fast,
    input wire logic tick_slow,
    input wire logic tick_wake,
    // Configuration and control
    input wire mtu_pkg::mtu_tcfg_t cfg,
    input wire logic start_req,
    input wire logic stop_req,
    input wire logic start_event,
    input wire logic stop_event,
    // Status
    output logic [15:0] count_r,
    output logic running_r,
    output logic underflow_r
);

    mtu_pkg::mtu_tstate_t state_r;
    logic tick;
    logic [15:0] reload;

    // Selected counting clock
    always_comb begin
        unique case (cfg.clk_sel)
            mtu_pkg::MTU_SEL_FAST: tick = tick_fast;
            mtu_pkg::MTU_SEL_SLOW: tick = tick_slow;
            mtu_pkg::MTU_SEL_WAKE: tick = tick_wake;
            default: tick = 1'b0;
        endcase
    end

    assign reload = {cfg.reload_high_byte, cfg.reload_low_byte};

    // Counter, state and running status
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_r <= mtu_pkg::MTU_T_IDLE;
            count_r <= `MTU_CNT_RST;
            running_r <= 1'b0;
            underflow_r <= 1'b0;
        end else begin
            underflow_r <= 1'b0;
            if (stop_req) begin
                state_r <= mtu_pkg::MTU_T_IDLE;
                running_r <= 1'b0;
            end else if (start_req) begin
                count_r <= reload;
                running_r <= 1'b1;
                if (cfg.start_evt_en) begin
                    state_r <= mtu_pkg::MTU_T_ARMED;
                end else begin
                    state_r <= mtu_pkg::MTU_T_COUNT;
                end
            end else begin
                unique case (state_r)
                    mtu_pkg::MTU_T_IDLE: begin
                        running_r <= 1'b0;
                    end
                    mtu_pkg::MTU_T_ARMED: begin
                        if (start_event) begin
                            state_r <= mtu_pkg::MTU_T_COUNT;
                        end
                    end
                    mtu_pkg::MTU_T_COUNT: begin
                        if (cfg.stop_evt_en && stop_event) begin
                            // Halt, keep count, no underflow
                            state_r <= mtu_pkg::MTU_T_IDLE;
                            running_r <= 1'b0;
                        end else if (tick && count_r == 16'h0000) begin
                            underflow_r <= 1'b1;
                            if (cfg.auto_reload_option) begin
                                count_r <= reload;
                            end else begin
                                state_r <= mtu_pkg::MTU_T_IDLE;
                                running_r <= 1'b0;
                            end
                        end else if (tick) begin
                            count_r <= count_r - 16'h0001;
                        end
                    end
                    default: begin
                        state_r <= mtu_pkg::MTU_T_IDLE;
                        running_r <= 1'b0;
                    end
                endcase
            end
        end
    end

endmodule
`default_nettype wire

/* rtl/mtu_wtimer.sv */
// Purpose: Wake timer counting slow oscillator ticks
// Assumes: Tick is the synchronised oscillator edge
// Notes:   Same zero-then-next-tick underflow as general timers
`timescale 1ns/10ps
`default_nettype none
`include "mtu_defines.svh"

module mtu_wtimer (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Oscillator tick
    input wire logic tick_osc,
    // Control
    input wire logic start_req,
    input wire logic stop_req,
    input wire logic auto_reload,
    input wire logic [15:0] reload,
    // Status
    output logic [15:0] count_r,
    output logic running_r,
    output logic underflow_r
);

    // Counter and running status
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            count_r <= `MTU_CNT_RST;
            running_r <= 1'b0;
            underflow_r <= 1'b0;
        end else begin
            underflow_r <= 1'b0;
            if (stop_req) begin
                running_r <= 1'b0;
            end else if (start_req) begin
                count_r <= reload;
                running_r <= 1'b1;
            end else if (running_r && tick_osc) begin
                if (count_r == 16'h0000) begin
                    underflow_r <= 1'b1;
                    if (auto_reload) begin
                        count_r <= reload;
                    end else begin
                        running_r <= 1'b0;
                    end
                end else begin
                    count_r <= count_r - 16'h0001;
                end
            end
        end
    end

endmodule
`default_nettype wire

/* rtl/mtu_top.sv */
// Purpose: Multi timer unit with four general timers and a wake timer
// Assumes: Control bits arrive as same-clock ports, osc pin is async
// Notes:   Counting clocks are enables derived from ref_clk
//
// Contract
// - Each general timer counts fast, slow or wake-underflow ticks.
// - Each timer has 16-bit counter and full-range 16-bit reload bytes.
// - Fifth timer counts only slow oscillator ticks, used for wake-up.
// - Global control starts and stops timers and shows running state.
// - A running timer decrements once per selected tick.
// - Tick seen at zero is an underflow raising the timer interrupt.
// - Software can set and clear each timer flag.
// - On underflow halt at zero, or reload and continue if auto-reload.
// - Running bit reads one while started, zero when stopped.
// - Strobe with running starts; strobe without running stops.
// - Per-timer mode start bit also starts the timer.
// - Start event begins counting; early stop event halts without irq.
// - Wake timer underflow brings the system out of standby.
// - With auto-wake, no card means back to standby; else stay awake.
// - Stop event freezes the count for elapsed-time computation.
// - Auto-reload with irq enabled interrupts every period.
// - Enabled timer events drive the interrupt request pin.
// - Timer flags sit in the second interrupt flag word, set on underflow.
`timescale 1ns/10ps
`default_nettype none
`include "mtu_defines.svh"

module mtu_top #(
    parameter int NUM_TIMERS = 4,
    parameter int SLOW_DIV = `MTU_SLOW_DIV
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Slow oscillator pin
    input wire logic slow_oscillator,
    // Per timer configuration
    input wire mtu_pkg::mtu_tcfg_t [NUM_TIMERS-1:0] tcfg,
    // Global control write
    input wire logic ctrl_wr,
    input wire mtu_pkg::mtu_ctrl_t global_timer_ctrl,
    // Per timer mode start pulses
    input wire logic [NUM_TIMERS-1:0] mode_start,
    // Protocol start and stop events
    input wire logic [NUM_TIMERS-1:0] start_event,
    input wire logic [NUM_TIMERS-1:0] stop_event,
    // Interrupt flag write, bit 7 selects set or clear
    input wire logic flag_wr,
    input wire logic [7:0] flag_wdata,
    // Wake timer control
    input wire logic wake_start,
    input wire logic wake_stop,
    input wire logic wake_timer_auto_reload,
    input wire logic wake_irq_en,
    input wire logic [7:0] wake_reload_high_byte,
    input wire logic [7:0] wake_reload_low_byte,
    // Power control and card detect result
    input wire logic auto_wake_option,
    input wire logic standby_req,
    input wire logic detect_done,
    input wire logic card_found,
    // Timer status
    output logic [NUM_TIMERS-1:0][15:0] timer_count,
    output logic [NUM_TIMERS-1:0] timer_running,
    output logic [15:0] wake_count,
    output logic wake_running,
    // Interrupt state
    output logic [7:0] second_irq_flags,
    output logic irq_out,
    // Power state
    output logic standby,
    output logic wake_pulse
);

    localparam logic [11:0] FAST_STEP =
        12'(`MTU_FAST_CLK_HZ / `MTU_FRAC_SCALE);
    localparam logic [11:0] FAST_MOD =
        12'(`MTU_REF_CLK_HZ / `MTU_FRAC_SCALE);
    localparam int SDW = $clog2(SLOW_DIV);
    localparam logic [SDW-1:0] SLOW_LAST = SDW'(SLOW_DIV - 1);

    logic [11:0] frac_acc_r;
    logic tick_fast_r;
    logic [SDW-1:0] slow_div_r;
    logic tick_slow_r;
    logic osc_meta_r;
    logic osc_sync_r;
    logic osc_prev_r;
    logic tick_osc;
    logic [NUM_TIMERS-1:0] start_req;
    logic [NUM_TIMERS-1:0] stop_req;
    logic [NUM_TIMERS-1:0] underflow;
    logic [NUM_TIMERS-1:0] irq_en_mask;
    logic wake_underflow;
    logic [7:0] flag_set_hw;
    logic [7:0] flag_en;
    logic [7:0] flags_nxt;
    mtu_pkg::mtu_pstate_t pstate_r;

    // Start decode of one timer from a control write
    function automatic logic mtu_start_dec(
        input logic wr,
        input logic strobe,
        input logic run
    );
        mtu_start_dec = wr & strobe & run;
    endfunction

    // Stop decode of one timer from a control write
    function automatic logic mtu_stop_dec(
        input logic wr,
        input logic strobe,
        input logic run
    );
        mtu_stop_dec = wr & strobe & ~run;
    endfunction

    // Fractional accumulator gives the fast rate on average
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            frac_acc_r <= 12'h000;
            tick_fast_r <= 1'b0;
        end else if (frac_acc_r + FAST_STEP >= FAST_MOD) begin
            frac_acc_r <= frac_acc_r + FAST_STEP - FAST_MOD;
            tick_fast_r <= 1'b1;
        end else begin
            frac_acc_r <= frac_acc_r + FAST_STEP;
            tick_fast_r <= 1'b0;
        end
    end

    // Slow rate divided down from fast ticks
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            slow_div_r <= '0;
            tick_slow_r <= 1'b0;
        end else begin
            tick_slow_r <= 1'b0;
            if (tick_fast_r) begin
                if (slow_div_r == SLOW_LAST) begin
                    slow_div_r <= '0;
                    tick_slow_r <= 1'b1;
                end else begin
                    slow_div_r <= slow_div_r + 1'b1;
                end
            end
        end
    end

    // Oscillator pin synchroniser and rising edge
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            osc_meta_r <= 1'b0;
            osc_sync_r <= 1'b0;
            osc_prev_r <= 1'b0;
        end else begin
            osc_meta_r <= slow_oscillator;
            osc_sync_r <= osc_meta_r;
            osc_prev_r <= osc_sync_r;
        end
    end

    assign tick_osc = osc_sync_r & ~osc_prev_r;

    // Start and stop requests per general timer
    always_comb begin
        for (int i = 0; i < NUM_TIMERS; i++) begin
            start_req[i] = mtu_start_dec(ctrl_wr,
                global_timer_ctrl.immediate_strobe[i],
                global_timer_ctrl.running[i]) | mode_start[i];
            stop_req[i] = mtu_stop_dec(ctrl_wr,
                global_timer_ctrl.immediate_strobe[i],
                global_timer_ctrl.running[i]);
        end
    end

    // Four general timers
    generate
        for (genvar g = 0; g < NUM_TIMERS; g++) begin : g_tmr
            mtu_gtimer u_gtimer (
                .ref_clk(ref_clk),
                .reset(reset),
                .tick_fast(tick_fast_r),
                .tick_slow(tick_slow_r),
                .tick_wake(wake_underflow),
                .cfg(tcfg[g]),
                .start_req(start_req[g]),
                .stop_req(stop_req[g]),
                .start_event(start_event[g]),
                .stop_event(stop_event[g]),
                .count_r(timer_count[g]),
                .running_r(timer_running[g]),
                .underflow_r(underflow[g])
            );
            assign irq_en_mask[g] = tcfg[g].irq_en;
        end
    endgenerate

    // Wake timer on the oscillator
    mtu_wtimer u_wtimer (
        .ref_clk(ref_clk),
        .reset(reset),
        .tick_osc(tick_osc),
        .start_req(wake_start),
        .stop_req(wake_stop),
        .auto_reload(wake_timer_auto_reload),
        .reload({wake_reload_high_byte, wake_reload_low_byte}),
        .count_r(wake_count),
        .running_r(wake_running),
        .underflow_r(wake_underflow)
    );

    // Hardware set sources and enables of the flag word
    always_comb begin
        flag_set_hw = 8'h00;
        flag_en = 8'h00;
        flag_set_hw[NUM_TIMERS-1:0] = underflow;
        flag_set_hw[`MTU_FLAG_WAKE_BIT] = wake_underflow;
        flag_en[NUM_TIMERS-1:0] = irq_en_mask;
        flag_en[`MTU_FLAG_WAKE_BIT] = wake_irq_en;
    end

    // Software set or clear, hardware set wins
    always_comb begin
        flags_nxt = second_irq_flags;
        if (flag_wr) begin
            if (flag_wdata[`MTU_FLAG_SETCLR_BIT]) begin
                flags_nxt = flags_nxt | {1'b0, flag_wdata[6:0]};
            end else begin
                flags_nxt = flags_nxt & ~{1'b0, flag_wdata[6:0]};
            end
        end
        flags_nxt = flags_nxt | flag_set_hw;
        flags_nxt[`MTU_FLAG_SETCLR_BIT] = 1'b0;
        flags_nxt[6:5] = 2'b00;
        for (int b = NUM_TIMERS; b < `MTU_FLAG_WAKE_BIT; b++) begin
            flags_nxt[b] = 1'b0;
        end
    end

    // Flag register and interrupt pin
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            second_irq_flags <= `MTU_FLAGS_RST;
            irq_out <= 1'b0;
        end else begin
            second_irq_flags <= flags_nxt;
            irq_out <= |(flags_nxt & flag_en);
        end
    end

    // Standby, wake and card detect sequencing
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pstate_r <= mtu_pkg::MTU_P_ACTIVE;
            standby <= 1'b0;
            wake_pulse <= 1'b0;
        end else begin
            wake_pulse <= 1'b0;
            unique case (pstate_r)
                mtu_pkg::MTU_P_ACTIVE: begin
                    if (standby_req) begin
                        pstate_r <= mtu_pkg::MTU_P_STANDBY;
                        standby <= 1'b1;
                    end
                end
                mtu_pkg::MTU_P_STANDBY: begin
                    if (wake_underflow) begin
                        pstate_r <= mtu_pkg::MTU_P_CHECK;
                        standby <= 1'b0;
                        wake_pulse <= 1'b1;
                    end
                end
                mtu_pkg::MTU_P_CHECK: begin
                    if (detect_done) begin
                        if (!card_found && auto_wake_option) begin
                            pstate_r <= mtu_pkg::MTU_P_STANDBY;
                            standby <= 1'b1;
                        end else begin
                            pstate_r <= mtu_pkg::MTU_P_ACTIVE;
                        end
                    end
                end
                default: begin
                    pstate_r <= mtu_pkg::MTU_P_ACTIVE;
                    standby <= 1'b0;
                end
            endcase
        end
    end

endmodule
`default_nettype wire

/* test/mtu_top_monitor.sv */
// Purpose: Port-level checks on the timer unit, timer 0 and power state
// Assumes: Bound into mtu_top, single ref_clk domain
// Notes:   Timer 0 stands for the four identical general timers
`timescale 1ns/10ps
`default_nettype none

module mtu_top_monitor #(
    parameter int NUM_TIMERS = 4
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Control inputs
    input wire mtu_pkg::mtu_tcfg_t [NUM_TIMERS-1:0] tcfg,
    input wire logic ctrl_wr,
    input wire mtu_pkg::mtu_ctrl_t global_timer_ctrl,
    input wire logic [NUM_TIMERS-1:0] mode_start,
    input wire logic [NUM_TIMERS-1:0] stop_event,
    input wire logic flag_wr,
    input wire logic [7:0] flag_wdata,
    input wire logic standby_req,
    // Outputs watched
    input wire logic [NUM_TIMERS-1:0][15:0] timer_count,
    input wire logic [NUM_TIMERS-1:0] timer_running,
    input wire logic [7:0] second_irq_flags,
    input wire logic irq_out,
    input wire logic standby,
    input wire logic wake_pulse
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    // Reload word of timer 0
    logic [15:0] rl0;
    logic strb0;
    assign rl0 = {tcfg[0].reload_high_byte, tcfg[0].reload_low_byte};
    assign strb0 = ctrl_wr && global_timer_ctrl.immediate_strobe[0];

    property p_start;
        strb0 && global_timer_ctrl.running[0] && !stop_event[0]
        |=> timer_running[0] && timer_count[0] == $past(rl0);
    endproperty
    a_start: assert property (p_start)
        else $error("start did not load reload");

    property p_stop;
        strb0 && !global_timer_ctrl.running[0] |=> !timer_running[0];
    endproperty
    a_stop: assert property (p_stop)
        else $error("strobe stop ignored");

    property p_mode;
        mode_start[0] && !strb0 && !stop_event[0] |=> timer_running[0];
    endproperty
    a_mode: assert property (p_mode)
        else $error("mode start ignored");

    property p_dec;
        $changed(timer_count[0]) && timer_running[0] && $past(timer_running[0])
        && !$past(ctrl_wr) && !$past(mode_start[0])
        |-> timer_count[0] == $past(timer_count[0]) - 16'h0001
        || timer_count[0] == rl0;
    endproperty
    a_dec: assert property (p_dec)
        else $error("count moved by other than one");

    property p_underflow;
        $fell(timer_running[0]) && !$past(ctrl_wr)
        && !$past(stop_event[0] && tcfg[0].stop_evt_en)
        |-> timer_count[0] == 16'h0000 ##1 second_irq_flags[0];
    endproperty
    a_underflow: assert property (p_underflow)
        else $error("underflow halt or flag wrong");

    property p_stop_evt;
        tcfg[0].stop_evt_en && stop_event[0] && timer_running[0] && !ctrl_wr
        && !mode_start[0] && $changed(timer_count[0])
        |=> !timer_running[0] ##1 $stable(timer_count[0]);
    endproperty
    a_stop_evt: assert property (p_stop_evt)
        else $error("stop event did not freeze");

    property p_flag_set;
        flag_wr && flag_wdata == 8'h81 |=> second_irq_flags[0];
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("software set lost");

    property p_flag_clr;
        flag_wr && flag_wdata == 8'h01 && !timer_running[0]
        && !$past(timer_running[0]) |=> !second_irq_flags[0];
    endproperty
    a_flag_clr: assert property (p_flag_clr)
        else $error("software clear lost");

    property p_irq;
        second_irq_flags[0] && $past(second_irq_flags[0])
        && tcfg[0].irq_en && $past(tcfg[0].irq_en) |-> irq_out;
    endproperty
    a_irq: assert property (p_irq)
        else $error("irq pin missing");

    property p_unused;
        second_irq_flags[7:5] == 3'h0;
    endproperty
    a_unused: assert property (p_unused)
        else $error("unused flag bits set");

    property p_wake;
        wake_pulse |-> !standby && $past(standby);
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake pulse outside standby exit");

    property p_sleep;
        standby_req && !standby && !wake_pulse |=> standby;
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("standby request ignored");
endmodule

bind mtu_top mtu_top_monitor #(.NUM_TIMERS(NUM_TIMERS)) u_mtu_top_monitor (
    .ref_clk(ref_clk), .reset(reset), .tcfg(tcfg), .ctrl_wr(ctrl_wr),
    .global_timer_ctrl(global_timer_ctrl), .mode_start(mode_start),
    .stop_event(stop_event), .flag_wr(flag_wr), .flag_wdata(flag_wdata),
    .standby_req(standby_req), .timer_count(timer_count),
    .timer_running(timer_running), .second_irq_flags(second_irq_flags),
    .irq_out(irq_out), .standby(standby), .wake_pulse(wake_pulse)
);
`default_nettype wire

/* test/mtu_top_bench.sv */
// Purpose: Self-checking bench of the multi timer unit
// Assumes: Inputs change on the falling edge of ref_clk
// Notes:   Slow oscillator toggles only while a wake scenario runs
`timescale 1ns/10ps
`default_nettype none

module mtu_top_bench;
    // Stimulus
    logic ref_clk = 1'b0, reset = 1'b1;
    logic slow_oscillator = 1'b0, osc_on = 1'b0;
    mtu_pkg::mtu_tcfg_t [3:0] tcfg = '0;
    logic ctrl_wr = 1'b0, flag_wr = 1'b0;
    mtu_pkg::mtu_ctrl_t global_timer_ctrl = '0;
    logic [3:0] mode_start = 4'h0, start_event = 4'h0, stop_event = 4'h0;
    logic [7:0] flag_wdata = 8'h00, wake_hi = 8'h00, wake_lo = 8'h00;
    logic wake_start = 1'b0, wake_stop = 1'b0;
    logic wake_timer_auto_reload = 1'b0, wake_irq_en = 1'b1;
    logic auto_wake_option = 1'b0, standby_req = 1'b0;
    logic detect_done = 1'b0, card_found = 1'b0;
    // Observed
    logic [3:0][15:0] timer_count;
    logic [3:0] timer_running;
    logic [15:0] wake_count;
    logic [7:0] second_irq_flags;
    logic wake_running, irq_out, standby, wake_pulse;
    int fails = 0, comparisons = 0;

    // Clocks
    always #20 ref_clk = ~ref_clk;
    always #150 slow_oscillator = osc_on ? ~slow_oscillator : 1'b0;

    mtu_top u_mtu_top (
        .ref_clk(ref_clk), .reset(reset), .slow_oscillator(slow_oscillator),
        .tcfg(tcfg), .ctrl_wr(ctrl_wr), .global_timer_ctrl(global_timer_ctrl),
        .mode_start(mode_start), .start_event(start_event),
        .stop_event(stop_event), .flag_wr(flag_wr), .flag_wdata(flag_wdata),
        .wake_start(wake_start), .wake_stop(wake_stop),
        .wake_timer_auto_reload(wake_timer_auto_reload),
        .wake_irq_en(wake_irq_en), .wake_reload_high_byte(wake_hi),
        .wake_reload_low_byte(wake_lo), .auto_wake_option(auto_wake_option),
        .standby_req(standby_req), .detect_done(detect_done),
        .card_found(card_found), .timer_count(timer_count),
        .timer_running(timer_running), .wake_count(wake_count),
        .wake_running(wake_running), .second_irq_flags(second_irq_flags),
        .irq_out(irq_out), .standby(standby), .wake_pulse(wake_pulse)
    );

    // Verdict and end of run
    task automatic wrap_up();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tmo(input logic ok);
        if (ok !== 1'b1) begin
            fails++;
            $display("[FAIL] %0t wait ran out", $time);
            wrap_up();
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // One-cycle write of the global control word
    task automatic ctrl(input logic [3:0] stb, input logic [3:0] run);
        cyc(1);
        ctrl_wr = 1'b1;
        global_timer_ctrl = {stb, run};
        cyc(1);
        ctrl_wr = 1'b0;
    endtask

    task automatic fwr(input logic [7:0] d);
        cyc(1);
        flag_wr = 1'b1;
        flag_wdata = d;
        cyc(1);
        flag_wr = 1'b0;
    endtask

    task automatic t_oneshot();
        int i;
        tcfg[0].irq_en = 1'b1;
        tcfg[0].reload_low_byte = 8'h03;
        ctrl(4'h1, 4'h1);
        chk(timer_running[0], 1'b1);
        chk(timer_count[0], 16'h0003);
        for (i = 0; i < 40 && timer_running[0] === 1'b1; i++)
            cyc(1);
        tmo(i < 40);
        chk(timer_count[0], 16'h0000);
        cyc(1);
        chk(second_irq_flags[0], 1'b1);
        chk(irq_out, 1'b1);
        fwr(8'h01);
        chk(second_irq_flags[0], 1'b0);
        chk(irq_out, 1'b0);
        fwr(8'h81);
        chk(second_irq_flags, 8'h01);
        fwr(8'h01);
        $display("oneshot test done");
    endtask

    task automatic t_periodic();
        int i;
        tcfg[1].auto_reload_option = 1'b1;
        tcfg[1].irq_en = 1'b1;
        tcfg[1].reload_low_byte = 8'h02;
        mode_start = 4'h3;
        cyc(1);
        mode_start = 4'h0;
        chk(timer_count[1], 16'h0002);
        for (int k = 0; k < 2; k++) begin
            for (i = 0; i < 40 && second_irq_flags[1] !== 1'b1; i++)
                cyc(1);
            tmo(i < 40);
            chk(timer_running[1], 1'b1);
            fwr(8'h03);
        end
        ctrl(4'h0, 4'hf);
        chk(timer_running, 4'h2);
        ctrl(4'h3, 4'h0);
        chk(timer_running[1], 1'b0);
        $display("periodic test done");
    endtask

    task automatic t_stopwatch();
        logic [15:0] d;
        int i;
        tcfg[0].start_evt_en = 1'b1;
        tcfg[0].stop_evt_en = 1'b1;
        tcfg[0].reload_high_byte = 8'h01;
        tcfg[0].reload_low_byte = 8'h00;
        ctrl(4'h1, 4'h1);
        cyc(10);
        chk(timer_count[0], 16'h0100);
        start_event = 4'h1;
        cyc(1);
        start_event = 4'h0;
        cyc(38);
        d = timer_count[0];
        for (i = 0; i < 4 && timer_count[0] === d; i++)
            cyc(1);
        tmo(i < 4);
        stop_event = 4'h1;
        cyc(1);
        stop_event = 4'h0;
        chk(timer_running[0], 1'b0);
        cyc(20);
        d = 16'h0100 - timer_count[0];
        chk(d >= 16'h0012 && d <= 16'h0018, 1'b1);
        chk(second_irq_flags[0], 1'b0);
        $display("stopwatch test done");
    endtask

    task automatic wait_wake();
        int i;
        for (i = 0; i < 300 && wake_pulse !== 1'b1; i++)
            cyc(1);
        tmo(i < 300);
        chk(standby, 1'b0);
    endtask

    task automatic t_wake();
        tcfg[3].clk_sel = mtu_pkg::MTU_SEL_WAKE;
        tcfg[3].irq_en = 1'b1;
        ctrl(4'h8, 4'h8);
        wake_lo = 8'h01;
        wake_timer_auto_reload = 1'b1;
        auto_wake_option = 1'b1;
        osc_on = 1'b1;
        wake_start = 1'b1;
        standby_req = 1'b1;
        cyc(1);
        wake_start = 1'b0;
        standby_req = 1'b0;
        chk(standby, 1'b1);
        chk(wake_count, 16'h0001);
        wait_wake();
        detect_done = 1'b1;
        cyc(1);
        detect_done = 1'b0;
        chk(standby, 1'b1);
        wait_wake();
        chk(second_irq_flags[4:3], 2'h3);
        auto_wake_option = 1'b0;
        detect_done = 1'b1;
        cyc(1);
        detect_done = 1'b0;
        cyc(5);
        chk(standby, 1'b0);
        wake_stop = 1'b1;
        cyc(1);
        wake_stop = 1'b0;
        chk(wake_running, 1'b0);
        $display("wake test done");
    endtask

    // Main sequence
    initial begin
        repeat (6) @(negedge ref_clk);
        reset = 1'b0;
        cyc(1);
        t_oneshot();
        t_periodic();
        t_stopwatch();
        t_wake();
        wrap_up();
    end
endmodule
`default_nettype wire
